//--- inc/bip_params.svh
// constants of the bidirectional i/o port bank
`ifndef BIP_PARAMS_SVH
`define BIP_PARAMS_SVH

// --------------------------------------------------------------
// register indices, byte address is four times the index
// --------------------------------------------------------------
`define BIP_IDX_DIR0 18'h0_FFE0
`define BIP_IDX_DIR1 18'h0_FFE1
`define BIP_IDX_DIR2 18'h0_FFE2
`define BIP_IDX_DIR3 18'h0_FFE3
`define BIP_IDX_DAT0 18'h0_FFE4
`define BIP_IDX_DAT1 18'h0_FFE5
`define BIP_IDX_DAT2 18'h0_FFE6
`define BIP_IDX_DAT3 18'h0_FFE7
`define BIP_IDX_CTRL 18'h0_FFE8

// --------------------------------------------------------------
// control register fields
// --------------------------------------------------------------
`define BIP_CTRL_SER_EN   0
`define BIP_CTRL_MODE_LO  1
`define BIP_CTRL_MODE_HI  2
`define BIP_CTRL_SER_HIGH 3
`define BIP_CTRL_EXP_BUS  4
`define BIP_CTRL_W        5
`define BIP_CTRL_RST      5'h00

// --------------------------------------------------------------
// widths and reset values
// --------------------------------------------------------------
`define BIP_PORT_W  8
`define BIP_PORT2_W 4
`define BIP_DIR_RST 8'h00
`define BIP_DAT_RST 8'hFF

`endif

//--- inc/bip_pkg.sv
// types of the bidirectional i/o port bank
package bip_pkg;
	// serial interface transfer modes, in control field order
	typedef enum logic [1:0] {
		BIP_SER_ASYNC,
		BIP_SER_SLAVE,
		BIP_SER_MASTER,
		BIP_SER_IRDA
	} bip_ser_mode_t;
	typedef logic [3:0][7:0] bip_bank_t;
endpackage

//--- rtl/bip_port_reg.sv
// direction and data storage of one port
`include "bip_params.svh"
module bip_port_reg
	import bip_pkg::*;
#(
	parameter int W = `BIP_PORT_W
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic         wr_dir,
	input  wire logic         wr_dat,
	input  wire logic [W-1:0] wdata,
	output logic      [W-1:0] dir,
	output logic      [W-1:0] dat
);
	logic [W-1:0] next_dir;
	logic [W-1:0] next_dat;

	// plain storage: what a pin does is decided by the bank
	always_comb begin
		next_dir = wr_dir ? wdata : dir;
		next_dat = wr_dat ? wdata : dat;
	end

	// pins start as inputs with data high
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dir <= W'(`BIP_DIR_RST);
			dat <= W'(`BIP_DAT_RST);
		end else begin
			dir <= next_dir;
			dat <= next_dat;
		end
	end
endmodule // bip_port_reg

//--- rtl/bip_serial_map.sv
// which port-1 pins the serial interface claims
module bip_serial_map
	import bip_pkg::*;
(
	input  wire logic          ser_en,
	input  wire bip_ser_mode_t mode,
	input  wire logic          ser_high,
	output logic               use_high,
	output logic         [7:0] claim
);
	logic [3:0] roles;

	// roles in order: data in, data out, clock, ready
	always_comb begin
		use_high = ser_high;
		case (mode)
			BIP_SER_ASYNC:  roles = 4'b0011;
			BIP_SER_SLAVE:  roles = 4'b1111;
			BIP_SER_MASTER: roles = 4'b0111;
			BIP_SER_IRDA: begin
				roles    = 4'b0011;
				use_high = 1'b1;
			end
			default:        roles = 4'b0000;
		endcase
		if (!ser_en)
			claim = 8'h00;
		else if (use_high)
			claim = {roles, 4'h0};
		else
			claim = {4'h0, roles};
	end
endmodule // bip_serial_map

//--- rtl/bip_io_port_bank.sv
// bidirectional i/o port bank with apb register access
//
// Design decisions made here: the placing of the registers and the APB register port.
`include "bip_params.svh"
module bip_io_port_bank
	import bip_pkg::*;
#(
	parameter logic [27:0] PULLUP_OPT = 28'hFFF_FFFF
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [19:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic  [7:0] p0_in,
	output logic       [7:0] p0_out,
	output logic       [7:0] p0_oe,
	output logic       [7:0] p0_pullup,
	input  wire logic  [7:0] p1_in,
	output logic       [7:0] p1_out,
	output logic       [7:0] p1_oe,
	output logic       [7:0] p1_pullup,
	input  wire logic  [3:0] p2_in,
	output logic       [3:0] p2_out,
	output logic       [3:0] p2_oe,
	output logic       [3:0] p2_pullup,
	input  wire logic  [7:0] p3_in,
	output logic       [7:0] p3_out,
	output logic       [7:0] p3_oe,
	output logic       [7:0] p3_pullup,
	input  wire logic  [7:0] bus_data_out,
	input  wire logic        bus_data_oe,
	output logic       [7:0] bus_data_in,
	input  wire logic        serial_data_out,
	input  wire logic        serial_clk_out,
	input  wire logic        serial_ready_out,
	input  wire logic        infrared_out,
	output logic             serial_data_in,
	output logic             serial_clk_in,
	output logic             infrared_in
);
	// --------------------------------------------------------------
	// declarations
	// --------------------------------------------------------------
	bip_bank_t pin_in;
	bip_bank_t dir;
	bip_bank_t dat;
	bip_bank_t next_oe;
	bip_bank_t next_out;
	logic [3:0] wr_dir;
	logic [3:0] wr_dat;
	logic [`BIP_CTRL_W-1:0] ctrl;
	logic [`BIP_CTRL_W-1:0] next_ctrl;
	logic [7:0]  claim;
	logic        use_high;
	logic        ser_en;
	logic        exp_bus;
	bip_ser_mode_t mode;
	logic        acc_done;
	logic        next_pready;
	logic        next_pslverr;
	logic [31:0] next_prdata;
	logic [27:0] next_pullup;
	logic        next_sin;
	logic        next_sclk;
	logic        next_iri;

	// true when the word address hits the given register index
	function automatic logic hit(input logic [19:0] a,
		input logic [17:0] idx);
		return a[19:2] == idx;
	endfunction

	// read value of one port: live pin in input mode unless a sub-function owns it, else storage
	function automatic logic [7:0] rd_port(input logic [7:0] d,
		input logic [7:0] v, input logic [7:0] p,
		input logic [7:0] own);
		return ((d | own) & v) | (~(d | own) & p);
	endfunction

	assign pin_in   = {p3_in, 4'h0, p2_in, p1_in, p0_in};
	assign ser_en   = ctrl[`BIP_CTRL_SER_EN];
	assign exp_bus  = ctrl[`BIP_CTRL_EXP_BUS];
	assign mode     = bip_ser_mode_t'(
		ctrl[`BIP_CTRL_MODE_HI:`BIP_CTRL_MODE_LO]);
	assign acc_done = psel & penable & pready;

	// --------------------------------------------------------------
	// register storage per port
	// --------------------------------------------------------------
	// writes take effect only on the completing access edge
	always_comb begin
		wr_dir[0] = acc_done & pwrite & hit(paddr, `BIP_IDX_DIR0);
		wr_dir[1] = acc_done & pwrite & hit(paddr, `BIP_IDX_DIR1);
		wr_dir[2] = acc_done & pwrite & hit(paddr, `BIP_IDX_DIR2);
		wr_dir[3] = acc_done & pwrite & hit(paddr, `BIP_IDX_DIR3);
		wr_dat[0] = acc_done & pwrite & hit(paddr, `BIP_IDX_DAT0);
		wr_dat[1] = acc_done & pwrite & hit(paddr, `BIP_IDX_DAT1);
		wr_dat[2] = acc_done & pwrite & hit(paddr, `BIP_IDX_DAT2);
		wr_dat[3] = acc_done & pwrite & hit(paddr, `BIP_IDX_DAT3);
	end

	// port 2 is narrow, its upper bits read as zero
	generate
		for (genvar g = 0; g < 4; g++) begin : g_port
			localparam int W = (g == 2) ? `BIP_PORT2_W : `BIP_PORT_W;
			bip_port_reg #(.W(W)) u_reg (
				.clk     (clk),
				.sys_rst (sys_rst),
				.wr_dir  (wr_dir[g]),
				.wr_dat  (wr_dat[g]),
				.wdata   (pwdata[W-1:0]),
				.dir     (dir[g][W-1:0]),
				.dat     (dat[g][W-1:0])
			);
			if (W < 8) begin : g_pad
				assign dir[g][7:W] = '0;
				assign dat[g][7:W] = '0;
			end
		end
	endgenerate

	// serial mode decode
	bip_serial_map u_map (
		.ser_en   (ser_en),
		.mode     (mode),
		.ser_high (ctrl[`BIP_CTRL_SER_HIGH]),
		.use_high (use_high),
		.claim    (claim)
	);

	// --------------------------------------------------------------
	// control register: serial enable, mode, group, bus mode
	// --------------------------------------------------------------
	always_comb begin
		next_ctrl = ctrl;
		if (acc_done & pwrite & hit(paddr, `BIP_IDX_CTRL))
			next_ctrl = pwdata[`BIP_CTRL_W-1:0];
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			ctrl <= `BIP_CTRL_RST;
		else
			ctrl <= next_ctrl;
	end

	// --------------------------------------------------------------
	// pin drivers
	// --------------------------------------------------------------
	// gpio by default, then sub-functions take their pins over
	always_comb begin
		next_oe  = dir;
		next_out = dat;
		if (exp_bus) begin
			next_oe[0]  = {8{bus_data_oe}};
			next_out[0] = bus_data_out;
		end
		for (int k = 0; k < 8; k++) begin
			if (claim[k]) begin
				case (k % 4)
					0: begin
						next_oe[1][k]  = 1'b0;
						next_out[1][k] = 1'b0;
					end
					1: begin
						next_oe[1][k]  = 1'b1;
						next_out[1][k] = (mode == BIP_SER_IRDA) ?
							infrared_out : serial_data_out;
					end
					2: begin
						// master makes the clock, slave takes it
						next_oe[1][k]  = (mode == BIP_SER_MASTER);
						next_out[1][k] = serial_clk_out;
					end
					default: begin
						next_oe[1][k]  = 1'b1;
						next_out[1][k] = serial_ready_out;
					end
				endcase
			end
		end
		next_oe[2][7:4]  = 4'h0;
		next_out[2][7:4] = 4'h0;
		// pull-up only where fitted and the pin is not driven
		next_pullup = PULLUP_OPT & ~{next_oe[3], next_oe[2][3:0],
			next_oe[1], next_oe[0]};
	end

	// registered so every pin output comes straight from a flop
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			p0_oe     <= 8'h00;
			p1_oe     <= 8'h00;
			p2_oe     <= 4'h0;
			p3_oe     <= 8'h00;
			p0_out    <= 8'hFF;
			p1_out    <= 8'hFF;
			p2_out    <= 4'hF;
			p3_out    <= 8'hFF;
			p0_pullup <= 8'h00;
			p1_pullup <= 8'h00;
			p2_pullup <= 4'h0;
			p3_pullup <= 8'h00;
		end else begin
			p0_oe     <= next_oe[0];
			p1_oe     <= next_oe[1];
			p2_oe     <= next_oe[2][3:0];
			p3_oe     <= next_oe[3];
			p0_out    <= next_out[0];
			p1_out    <= next_out[1];
			p2_out    <= next_out[2][3:0];
			p3_out    <= next_out[3];
			p0_pullup <= next_pullup[7:0];
			p1_pullup <= next_pullup[15:8];
			p2_pullup <= next_pullup[19:16];
			p3_pullup <= next_pullup[27:20];
		end
	end

	// --------------------------------------------------------------
	// sub-function inputs
	// --------------------------------------------------------------
	always_comb begin
		next_sin  = use_high ? p1_in[4] : p1_in[0];
		next_sclk = use_high ? p1_in[6] : p1_in[2];
		next_iri  = p1_in[4];
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			bus_data_in    <= 8'h00;
			serial_data_in <= 1'b1;
			serial_clk_in  <= 1'b1;
			infrared_in    <= 1'b1;
		end else begin
			bus_data_in    <= p0_in;
			serial_data_in <= next_sin;
			serial_clk_in  <= next_sclk;
			infrared_in    <= next_iri;
		end
	end

	// --------------------------------------------------------------
	// apb slave: one wait state, read data sampled with it
	// --------------------------------------------------------------
	always_comb begin
		next_pready  = psel & penable & ~pready;
		next_prdata  = prdata;
		next_pslverr = pslverr;
		if (next_pready) begin
			next_prdata  = 32'h0000_0000;
			next_pslverr = 1'b0;
			if (hit(paddr, `BIP_IDX_DIR0))
				next_prdata[7:0] = dir[0];
			else if (hit(paddr, `BIP_IDX_DIR1))
				next_prdata[7:0] = dir[1];
			else if (hit(paddr, `BIP_IDX_DIR2))
				next_prdata[7:0] = dir[2];
			else if (hit(paddr, `BIP_IDX_DIR3))
				next_prdata[7:0] = dir[3];
			else if (hit(paddr, `BIP_IDX_DAT0))
				next_prdata[7:0] = rd_port(dir[0], dat[0], pin_in[0],
					{8{exp_bus}});
			else if (hit(paddr, `BIP_IDX_DAT1))
				next_prdata[7:0] = rd_port(dir[1], dat[1], pin_in[1],
					claim);
			else if (hit(paddr, `BIP_IDX_DAT2))
				next_prdata[7:0] = rd_port(dir[2], dat[2], pin_in[2],
					8'h00);
			else if (hit(paddr, `BIP_IDX_DAT3))
				next_prdata[7:0] = rd_port(dir[3], dat[3], pin_in[3],
					8'h00);
			else if (hit(paddr, `BIP_IDX_CTRL))
				next_prdata[`BIP_CTRL_W-1:0] = ctrl;
			else
				next_pslverr = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= next_pready;
			pslverr <= next_pslverr;
			prdata  <= next_prdata;
		end
	end

	// --------------------------------------------------------------
	// assertions
	// --------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	AST_IN_MODE_OFF: assert property (
		!dir[3][0] |=> !p3_oe[0])
		else $error("input mode pin is driven");
	AST_OUT_DRIVES: assert property (
		dir[3][1] |=> p3_oe[1] && p3_out[1] == $past(dat[3][1]))
		else $error("output mode pin not driving data");
	AST_READ_LIVE: assert property (
		psel && penable && !pready && hit(paddr, `BIP_IDX_DAT3)
		&& dir[3] == 8'h00 |=> prdata[7:0] == $past(p3_in))
		else $error("input mode read not live pin");
	AST_READ_STORED: assert property (
		psel && penable && !pready && hit(paddr, `BIP_IDX_DAT3)
		&& dir[3] == 8'hFF |=> prdata[7:0] == $past(dat[3]))
		else $error("output mode read not stored data");
	AST_WRITE_IN_MODE: assert property (
		wr_dat[3] && dir[3] == 8'h00 |=> dat[3] == $past(pwdata[7:0])
		&& p3_oe == 8'h00)
		else $error("input mode data write misbehaved");
	AST_SER_OWNS: assert property (
		ser_en && mode == BIP_SER_ASYNC && !use_high
		|=> p1_oe[1] && !p1_oe[0] && p1_out[1] == $past(serial_data_out))
		else $error("serial pins not owned");
	AST_SER_LEAVES: assert property (
		ser_en && mode == BIP_SER_ASYNC && !use_high
		|=> p1_oe[7] == $past(dir[1][7]))
		else $error("unclaimed pin lost gpio control");
	AST_BUS_DATA: assert property (
		exp_bus |=> p0_oe == {8{$past(bus_data_oe)}}
		&& p0_out == $past(bus_data_out))
		else $error("port 0 not data bus");
	AST_PULLUP_IN: assert property (
		(p3_pullup & p3_oe) == 8'h00 && (p1_pullup & p1_oe) == 8'h00)
		else $error("pull-up on while driving");
	AST_APB_ONE_WAIT: assert property (
		psel && penable && !pready |=> pready)
		else $error("apb answer late");

	COV_SER_SLAVE: cover property (
		ser_en && mode == BIP_SER_SLAVE && use_high);
	COV_IRDA: cover property (ser_en && mode == BIP_SER_IRDA);
	COV_EXP_BUS: cover property (exp_bus && bus_data_oe);
	COV_UNMAPPED: cover property (pready && pslverr);
endmodule // bip_io_port_bank

//--- sim/bip_pin_model.sv
// pin-side model of the port bank: external drivers and pull-ups
module bip_pin_model
	import bip_pkg::*;
#(
	parameter int W = 28
) (
	input  wire logic         clk,
	input  wire logic [W-1:0] pin_out,
	input  wire logic [W-1:0] pin_oe,
	input  wire logic [W-1:0] pin_pullup,
	input  wire logic [W-1:0] ext_drv,
	input  wire logic [W-1:0] ext_en,
	output logic      [W-1:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [W-1:0] last;

	// a floating pin toggles so a stale level never reads as valid
	always_ff @(posedge clk) begin
		last <= pin_in;
	end

	// ----------------------------------------------------------
	// wire level: device driver, then external, then pull-up
	// ----------------------------------------------------------
	always_comb begin
		for (int i = 0; i < W; i++) begin
			if (pin_oe[i])
				pin_in[i] = pin_out[i];
			else if (ext_en[i])
				pin_in[i] = ext_drv[i];
			else if (pin_pullup[i])
				pin_in[i] = 1'b1;
			else
				pin_in[i] = ~last[i];
		end
	end
endmodule // bip_pin_model

//--- sim/tb_bip_io_port_bank.sv
// self-checking bench of the i/o port bank
`include "bip_params.svh"
module tb_bip_io_port_bank
	import bip_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, sys_rst, psel, penable, pwrite, pready, pslverr;
	logic [19:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [27:0] p_in, p_out, p_oe, p_pu, ext_drv, ext_en;
	logic [7:0] bus_do, bus_di;
	logic bus_oe, s_di, s_ci, ir_i, s_do, ir_o, err, s_co, s_ro;
	int n_fail, n_compared;

	bip_io_port_bank bip_io_port_bank_i (.clk(clk), .sys_rst(sys_rst),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .p0_in(p_in[7:0]), .p0_out(p_out[7:0]),
		.p0_oe(p_oe[7:0]), .p0_pullup(p_pu[7:0]), .p1_in(p_in[15:8]),
		.p1_out(p_out[15:8]), .p1_oe(p_oe[15:8]), .p1_pullup(p_pu[15:8]),
		.p2_in(p_in[19:16]), .p2_out(p_out[19:16]), .p2_oe(p_oe[19:16]),
		.p2_pullup(p_pu[19:16]), .p3_in(p_in[27:20]),
		.p3_out(p_out[27:20]), .p3_oe(p_oe[27:20]),
		.p3_pullup(p_pu[27:20]), .bus_data_out(bus_do),
		.bus_data_oe(bus_oe), .bus_data_in(bus_di),
		.serial_data_out(s_do), .serial_clk_out(s_co),
		.serial_ready_out(s_ro), .infrared_out(ir_o),
		.serial_data_in(s_di), .serial_clk_in(s_ci), .infrared_in(ir_i));

	bip_pin_model bip_pin_model_i (.clk(clk), .pin_out(p_out),
		.pin_oe(p_oe), .pin_pullup(p_pu), .ext_drv(ext_drv),
		.ext_en(ext_en), .pin_in(p_in));

	// ----------------------------------------------------------
	// helpers
	// ----------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			$display("FAIL %s expected %h seen %h", nm, e, g);
			n_fail++;
		end
	endtask

	// apb transfer; holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [17:0] idx,
		input logic [31:0] wd);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		// no cycle count assumed: only the watchdog ends a hung wait
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic conclude;
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ----------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------
	task automatic t_reset;
		for (int i = 0; i < 4; i++) begin
			apb(0, `BIP_IDX_DIR0 + 18'(i), 0);
			chk("dir", 0, rd);
			apb(0, `BIP_IDX_DAT0 + 18'(i), 0);
			chk("dat", (i == 2) ? 32'h0000_000F : 32'h0000_00FF, rd);
		end
		chk("oe", 0, 32'(p_oe));
		chk("pullup", 32'h0FFF_FFFF, 32'(p_pu));
		$display("test reset done");
	endtask

	task automatic t_gpio;
		ext_drv <= 28'h030_0000;
		ext_en <= 28'h0F0_0000;
		apb(1, `BIP_IDX_DAT3, 32'h0000_00A5);
		apb(1, `BIP_IDX_DIR3, 32'h0000_00F0);
		repeat (3) @(posedge clk);
		chk("p3 oe", 8'hF0, p_oe[27:20]);
		chk("p3 out", 8'hA0, {p_out[27:24], 4'h0});
		chk("p3 pullup", 8'h0F, p_pu[27:20]);
		apb(0, `BIP_IDX_DAT3, 0);
		chk("p3 read", 8'hA3, rd);
		apb(1, `BIP_IDX_DAT3, 32'h0000_005C);
		repeat (2) @(posedge clk);
		chk("p3 pins", 8'h53, p_in[27:20]);
		chk("p3 oe in", 8'hF0, p_oe[27:20]);
		apb(1, `BIP_IDX_DAT3, 32'h0000_FFFF);
		repeat (2) @(posedge clk);
		chk("p3 pins", 8'hF3, p_in[27:20]);
		apb(1, `BIP_IDX_DIR3, 0);
		repeat (2) @(posedge clk);
		chk("p3 off", 0, p_oe[27:20]);
		$display("test gpio done");
	endtask

	task automatic t_serial;
		logic [7:0] cl[4], ro[4], hi[4], eo;
		int sh;
		cl = '{8'h03, 8'h0F, 8'h07, 8'h30};
		ro = '{8'h02, 8'h0A, 8'h06, 8'h20};
		hi = '{8'h02, 8'h0A, 8'h06, 8'h00};
		// serial data, clock and ready levels differ from gpio data, so ownership shows; the infrared level does not
		ext_drv <= 28'h000_FF00;
		ext_en <= 28'hFFF_FFFF;
		s_do <= 1'b1;
		ir_o <= 1'b0;
		apb(1, `BIP_IDX_DIR1, 32'h0000_00FF);
		apb(1, `BIP_IDX_DAT1, 0);
		for (int m = 0; m < 4; m++) begin
			for (int h = 0; h < 2; h++) begin
				sh = (m != 3 && h == 1) ? 4 : 0;
				eo = ~(cl[m] << sh) | (ro[m] << sh);
				apb(1, `BIP_IDX_CTRL, {h[0], m[1:0], 1'b1});
				repeat (3) @(posedge clk);
				chk("p1 oe", eo, p_oe[15:8]);
				chk("p1 out", hi[m] << sh, p_out[15:8] & eo);
				chk("ser in", 1, (m == 3) ? ir_i : s_di);
				chk("ser clk", 32'(m == 1 || m == 2), s_ci);
			end
		end
		apb(0, `BIP_IDX_DIR1, 0);
		chk("dir1", 8'hFF, rd);
		apb(0, `BIP_IDX_DAT1, 0);
		chk("dat1", 0, rd);
		apb(1, `BIP_IDX_CTRL, 0);
		repeat (3) @(posedge clk);
		chk("p1 gpio", 8'hFF, p_oe[15:8]);
		$display("test serial done");
	endtask

	task automatic t_bus;
		apb(1, `BIP_IDX_DAT0, 32'h0000_0011);
		apb(1, `BIP_IDX_CTRL, 32'h0000_0010);
		bus_oe <= 1'b1;
		repeat (3) @(posedge clk);
		chk("bus oe", 8'hFF, p_oe[7:0]);
		chk("bus out", 8'h5A, p_out[7:0]);
		bus_oe <= 1'b0;
		ext_drv <= 28'h000_00C3;
		repeat (3) @(posedge clk);
		chk("bus in", 8'hC3, bus_di);
		apb(0, `BIP_IDX_DAT0, 0);
		chk("dat0", 8'h11, rd);
		apb(0, `BIP_IDX_CTRL + 18'd1, 0);
		chk("unmapped err", 1, err);
		chk("unmapped rd", 0, rd);
		$display("test bus done");
	endtask

	// reset in mid-run after software changed direction and data
	task automatic t_rerun;
		apb(1, `BIP_IDX_DIR3, 32'h0000_00FF);
		apb(1, `BIP_IDX_DAT3, 32'h0000_003C);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		chk("rst oe", 0, 32'(p_oe));
		chk("rst out", 32'h0FFF_FFFF, 32'(p_out));
		sys_rst <= 1'b0;
		@(posedge clk);
		apb(0, `BIP_IDX_DIR3, 0);
		chk("dir3", 0, rd);
		apb(1, `BIP_IDX_DIR3, 32'h0000_00FF);
		apb(0, `BIP_IDX_DAT3, 0);
		chk("dat3", 8'hFF, rd);
		apb(0, `BIP_IDX_CTRL, 0);
		chk("ctrl", 0, rd);
		$display("test rerun done");
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		#50000;
		n_fail++;
		conclude();
	end

	initial begin
		{psel, penable, pwrite, bus_oe, s_do} = '0;
		{paddr, pwdata, ext_drv, ext_en} = '0;
		{bus_do, ir_o, sys_rst, s_co, s_ro} = {8'h5A, 4'hF};
		n_fail = 0;
		n_compared = 0;
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_gpio();
		t_serial();
		t_bus();
		t_rerun();
		conclude();
	end
endmodule // tb_bip_io_port_bank
